// file: include/scp_regs.svh
// Operation
// - frame is 35 bits: 4 reset, 22 security, 9 config
// - idle chain reloads switch settings every cycle
// - idle bit counter held cleared at zero
// - debounced request releases counter, enables shifting
// - gate sets on first bit clock rising edge after first bit staged on pin
// - comparator goes low when count reaches 35
// - comparator low clears gate, stopping the clock
// - data bit driven with gated clock to target
// - counting only while request held, 4.4 ms total
// - count end fires 13 ms ramp enable one-shot
// - one-shot held cleared until power-on delay elapses
// - request release returns to idle and reload
// - open switch reads one, closed reads zero
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SCP_FRAME_BITS      35
`define SCP_RESET_BITS      4
`define SCP_SEC_BITS        22
`define SCP_CFG_BITS        9
`define SCP_SW_BITS         31
`define SCP_CNT_W           7
`define SCP_CMP_WIRED       8'hc4
`define SCP_RESET_PATTERN   4'h0
`define SCP_FIFO_DEPTH      16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCP_CLK_PERIOD_NS   10
`define SCP_TMR_W           21
`define SCP_ONESHOT_MS      13
`define SCP_POR_US          220
`define SCP_DEBOUNCE_US     1000
`define SCP_ONESHOT_CYC     (21'((`SCP_ONESHOT_MS * 1000000) / `SCP_CLK_PERIOD_NS))
`define SCP_POR_CYC         (21'((`SCP_POR_US * 1000) / `SCP_CLK_PERIOD_NS))
`define SCP_DEB_CYC         (21'((`SCP_DEBOUNCE_US * 1000) / `SCP_CLK_PERIOD_NS))

`endif

// file: include/scp_pkg.sv
`include "scp_regs.svh"
package scp_pkg;

    // sequencer phases
    typedef enum logic [1:0]
    {
        SCP_IDLE  = 2'b00,
        SCP_ARM   = 2'b01,
        SCP_SHIFT = 2'b10,
        SCP_DONE  = 2'b11
    } scp_phase_t;

    // whole state of the programmer except the bit buffer
    typedef struct packed
    {
        scp_phase_t                  phase;
        logic                        bclk_meta;
        logic                        bclk_sync;
        logic                        bclk_prev;
        logic                        btn_meta;
        logic                        btn_sync;
        logic                        req;
        logic [`SCP_TMR_W-1:0]       deb_cnt;
        logic [`SCP_SW_BITS-1:0]     sw_meta;
        logic [`SCP_SW_BITS-1:0]     sw_sync;
        logic                        gate;
        logic [`SCP_CNT_W-1:0]       count;
        logic [`SCP_FRAME_BITS-1:0]  chain;
        logic                        pushed;
        logic                        consumed;
        logic                        data_reg;
        logic                        clk_out;
        logic                        cmp_prev;
        logic                        por_done;
        logic [`SCP_TMR_W-1:0]       por_cnt;
        logic [`SCP_TMR_W-1:0]       os_cnt;
        logic                        os_on;
    } scp_state_t;

endpackage

// file: include/scp_stream_if.sv
`timescale 1ns/100ps
// valid/ready bit stream between the sequencer and its buffer
interface scp_stream_if #(parameter int WIDTH = 1);
    logic             valid;    // source holds a word
    logic             ready;    // sink accepts a word
    logic [WIDTH-1:0] data;     // the word itself

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: logic/scp_fifo.sv
`timescale 1ns/100ps
`include "scp_regs.svh"
module scp_fifo
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = `SCP_FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    // filling and draining sides
    scp_stream_if.snk   push_if,
    scp_stream_if.src   pop_if
);
    // depth must be a power of two so the pointers wrap naturally
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 fill;
    } scp_fifo_state_t;

    scp_fifo_state_t st_reg;    // registered state
    scp_fifo_state_t st_next;   // next state
    logic            do_push;   // word taken in
    logic            do_pop;    // word handed out

    // honest flags straight from the fill level
    assign push_if.ready = (st_reg.fill != (AW+1)'(DEPTH));
    assign pop_if.valid  = (st_reg.fill != '0);
    assign pop_if.data   = st_reg.mem[st_reg.rptr];
    assign do_push       = push_if.valid & push_if.ready;
    assign do_pop        = pop_if.valid & pop_if.ready;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (do_push)
        begin
            st_next.mem[st_reg.wptr] = push_if.data;
            st_next.wptr = st_reg.wptr + 1'h1;
        end
        if (do_pop)
            st_next.rptr = st_reg.rptr + 1'h1;
        if (do_push && !do_pop)
            st_next.fill = st_reg.fill + 1'h1;
        else if (do_pop && !do_push)
            st_next.fill = st_reg.fill - 1'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // a full buffer refuses, yet still offers a word to the sink
    property p_fifo_flags;
        (st_reg.fill == (AW+1)'(DEPTH)) |-> !push_if.ready && pop_if.valid;
    endproperty
    a_fifo_flags: assert property (p_fifo_flags)
        else $error("fifo full flag wrong");

    property p_fifo_fill;
        (do_push && !do_pop) |=> st_reg.fill == $past(st_reg.fill) + 1'h1;
    endproperty
    a_fifo_fill: assert property (p_fifo_fill)
        else $error("fifo fill level did not rise");
endmodule

// file: logic/scp_programmer.sv
`timescale 1ns/100ps
`include "scp_regs.svh"
module scp_programmer
#(
    parameter logic [`SCP_RESET_BITS-1:0] RESET_PATTERN   = `SCP_RESET_PATTERN,
    parameter logic [`SCP_TMR_W-1:0]      DEBOUNCE_CYCLES = `SCP_DEB_CYC,
    parameter logic [`SCP_TMR_W-1:0]      ONESHOT_CYCLES  = `SCP_ONESHOT_CYC,
    parameter logic [`SCP_TMR_W-1:0]      POR_CYCLES      = `SCP_POR_CYC,
    parameter int                         FIFO_DEPTH      = `SCP_FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     sys_rst_in,
    // operator controls, raw from the panel
    input  wire logic                     program_request_button_in,
    input  wire logic [`SCP_SW_BITS-1:0]  code_switches_closed_in,
    // free-running bit clock
    input  wire logic                     bit_clk_in,
    // target chip side
    output logic                          code_data_out,
    output logic                          osc_resistor_pin_out,
    output logic                          osc_capacitor_pin_ramp_out,
    // status
    output logic                          busy_out
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    // the wired compare pattern reads lsb first, so reverse it once
    localparam logic [7:0] CMP_VALUE = {<<{`SCP_CMP_WIRED}};
    localparam logic [`SCP_CNT_W-1:0] FRAME_COUNT =
        `SCP_CNT_W'(`SCP_FRAME_BITS);

    scp_pkg::scp_state_t              st_reg;     // registered state
    scp_pkg::scp_state_t              st_next;    // next state
    logic                             bclk_rise;  // bit clock rose
    logic                             arm_edge;   // gate opens now
    logic                             tick;       // one gated clock edge
    logic                             cmp_n;      // low at full count
    logic [`SCP_FRAME_BITS-1:0]       load_val;   // frame from switches

    // carriers to and from the bit buffer
    scp_stream_if #(.WIDTH(1)) bit_in_if ();
    scp_stream_if #(.WIDTH(1)) bit_out_if ();

    // ----------------------------------------------------------------
    // bit buffer
    // ----------------------------------------------------------------
    // decouples the shift chain from the pin stage; a stalled pin stage
    // backs up into the chain, which keeps offering its head bit but still shifts on each tick
    scp_fifo
    #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_in  (ref_clk_in),
        .rst_in  (sys_rst_in),
        .push_if (bit_in_if),
        .pop_if  (bit_out_if)
    );

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    // edge found on the synchronised copy only
    assign bclk_rise = st_reg.bclk_sync & ~st_reg.bclk_prev;

    // equality compare against the wired constant, active low
    assign cmp_n = ({1'h0, st_reg.count} != CMP_VALUE);

    // reset pulses lead, then security and config; open switch is one
    assign load_val = {RESET_PATTERN, ~st_reg.sw_sync};

    // first edge only once the first bit is staged on the pin
    assign arm_edge = (st_reg.phase == scp_pkg::SCP_ARM) & bclk_rise
                    & ~st_reg.consumed & st_reg.req;

    // the clock reaches the counter only through the gate or as the arming edge
    assign tick = bclk_rise & st_reg.req
                & (((st_reg.phase == scp_pkg::SCP_SHIFT) & st_reg.gate
                    & cmp_n) | arm_edge);

    // offer the chain head once per bit while a frame runs
    assign bit_in_if.valid = ((st_reg.phase == scp_pkg::SCP_ARM)
                           | (st_reg.phase == scp_pkg::SCP_SHIFT))
                           & st_reg.req & ~st_reg.pushed & cmp_n;
    assign bit_in_if.data  = st_reg.chain[`SCP_FRAME_BITS-1];

    // pin stage takes a new bit once the old one was clocked out
    assign bit_out_if.ready = st_reg.consumed;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;

        // two-stage synchronisers for every pin input
        st_next.bclk_meta = bit_clk_in;
        st_next.bclk_sync = st_reg.bclk_meta;
        st_next.bclk_prev = st_reg.bclk_sync;
        st_next.btn_meta  = program_request_button_in;
        st_next.btn_sync  = st_reg.btn_meta;
        st_next.sw_meta   = code_switches_closed_in;
        st_next.sw_sync   = st_reg.sw_meta;

        // debounce: level follows button only after it stays put
        if (st_reg.btn_sync == st_reg.req)
            st_next.deb_cnt = '0;
        else if (st_reg.deb_cnt >= DEBOUNCE_CYCLES - 1'h1)
        begin
            st_next.req     = st_reg.btn_sync;
            st_next.deb_cnt = '0;
        end
        else
            st_next.deb_cnt = st_reg.deb_cnt + 1'h1;

        // sequencer
        case (st_reg.phase)
            scp_pkg::SCP_IDLE:
            begin
                // released counter and shift mode follow the level
                if (st_reg.req)
                    st_next.phase = scp_pkg::SCP_ARM;
            end
            scp_pkg::SCP_ARM:
            begin
                if (arm_edge)
                begin
                    st_next.gate  = 1'h1;
                    st_next.phase = scp_pkg::SCP_SHIFT;
                end
            end
            scp_pkg::SCP_SHIFT:
            begin
                // full count closes the gate, no more edges pass
                if (!cmp_n)
                begin
                    st_next.gate  = 1'h0;
                    st_next.phase = scp_pkg::SCP_DONE;
                end
            end
            scp_pkg::SCP_DONE:
            begin
                // wait here for the button to be let go
                st_next.phase = scp_pkg::SCP_DONE;
            end
            default:
            begin
                st_next.phase = scp_pkg::SCP_IDLE;
            end
        endcase

        // pin stage takes the next bit from the buffer
        if (bit_out_if.valid && st_reg.consumed)
        begin
            st_next.data_reg = bit_out_if.data;
            st_next.consumed = 1'h0;
        end

        // chain head accepted by the buffer
        if (bit_in_if.valid && bit_in_if.ready)
            st_next.pushed = 1'h1;

        // one gated edge: count, shift msb first, release the pin bit
        if (tick)
        begin
            st_next.count    = st_reg.count + 1'h1;
            st_next.chain    = {st_reg.chain[`SCP_FRAME_BITS-2:0], 1'h0};
            st_next.pushed   = 1'h0;
            st_next.consumed = 1'h1;
        end

        // no request: counter cleared, chain tracks the switches
        if (!st_reg.req)
        begin
            st_next.phase    = scp_pkg::SCP_IDLE;
            st_next.gate     = 1'h0;
            st_next.count    = '0;
            st_next.chain    = load_val;
            st_next.pushed   = 1'h0;
            st_next.consumed = 1'h1;
        end

        // gated clock to the target; a started high phase is kept to
        // its end so the target never sees a runt pulse
        st_next.clk_out = st_reg.bclk_sync
                        & (st_next.gate | st_reg.clk_out);

        // power-on delay runs once after reset
        if (!st_reg.por_done)
        begin
            st_next.por_cnt = st_reg.por_cnt + 1'h1;
            if (st_reg.por_cnt >= POR_CYCLES - 1'h1)
                st_next.por_done = 1'h1;
        end

        // one-shot fired by the falling comparator output
        st_next.cmp_prev = cmp_n;
        if (!st_reg.por_done)
            st_next.os_cnt = '0;
        else if (st_reg.cmp_prev && !cmp_n)
            st_next.os_cnt = ONESHOT_CYCLES;
        else if (st_reg.os_cnt != '0)
            st_next.os_cnt = st_reg.os_cnt - 1'h1;
        st_next.os_on = (st_next.os_cnt != '0);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // outputs straight from flip-flops, busy decoded from the phase
    assign code_data_out              = st_reg.data_reg;
    assign osc_resistor_pin_out       = st_reg.clk_out;
    assign osc_capacitor_pin_ramp_out = st_reg.os_on;
    assign busy_out                   = (st_reg.phase != scp_pkg::SCP_IDLE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_count_full;
        (st_reg.phase == scp_pkg::SCP_SHIFT) && (st_reg.count == FRAME_COUNT);
    endsequence

    sequence s_stopped;
        !st_reg.gate && (st_reg.phase == scp_pkg::SCP_DONE);
    endsequence

    property p_frame_len;
        (st_reg.count == FRAME_COUNT) |-> !tick;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("edge passed after full frame");

    // the edge that releases reset still loads zeros, so it is skipped
    property p_idle_load;
        !sys_rst_in && !st_reg.req
            |=> st_reg.chain == {RESET_PATTERN, ~$past(st_reg.sw_sync)};
    endproperty
    a_idle_load: assert property (p_idle_load)
        else $error("chain did not reload switches");

    property p_idle_clear;
        !st_reg.req |=> (st_reg.count == '0) && !st_reg.gate;
    endproperty
    a_idle_clear: assert property (p_idle_clear)
        else $error("counter not held clear");

    property p_req_arm;
        $rose(st_reg.req) && (st_reg.phase == scp_pkg::SCP_IDLE)
            |=> (st_reg.phase == scp_pkg::SCP_ARM) && busy_out;
    endproperty
    a_req_arm: assert property (p_req_arm)
        else $error("request did not arm");

    property p_gate_on;
        arm_edge |=> st_reg.gate && osc_resistor_pin_out
            && (st_reg.count == 1);
    endproperty
    a_gate_on: assert property (p_gate_on)
        else $error("gate did not open on edge");

    property p_stop;
        s_count_full |-> !cmp_n ##1 s_stopped ##1 s_stopped;
    endproperty
    a_stop: assert property (p_stop)
        else $error("full count did not stop clock");

    property p_data_stable;
        $rose(osc_resistor_pin_out) |-> $stable(code_data_out);
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data moved on clock edge");

    property p_count_held;
        (st_reg.count > $past(st_reg.count)) |-> $past(st_reg.req);
    endproperty
    a_count_held: assert property (p_count_held)
        else $error("counted without request");

    property p_oneshot;
        st_reg.por_done && st_reg.cmp_prev && !cmp_n
            |=> (st_reg.os_cnt == ONESHOT_CYCLES) && osc_capacitor_pin_ramp_out
            ##1 osc_capacitor_pin_ramp_out [*7];
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot did not fire");

    property p_por;
        !st_reg.por_done |-> !osc_capacitor_pin_ramp_out;
    endproperty
    a_por: assert property (p_por)
        else $error("ramp enabled before power-on delay");

    property p_release;
        $fell(st_reg.req) |=> (st_reg.phase == scp_pkg::SCP_IDLE) && !busy_out;
    endproperty
    a_release: assert property (p_release)
        else $error("release did not return to idle");

    property p_shift;
        tick |=> st_reg.chain == ($past(st_reg.chain) << 1);
    endproperty
    a_shift: assert property (p_shift)
        else $error("chain did not shift msb first");

    // a closed gate lets no new pulse reach the target; only the
    // arming edge may start one, so a stray bit clock edge is harmless
    property p_no_runt;
        !st_reg.gate && !st_reg.clk_out && !arm_edge
            |=> !osc_resistor_pin_out;
    endproperty
    a_no_runt: assert property (p_no_runt)
        else $error("clock pulse passed a closed gate");

    // once fired the one-shot steps down once a cycle, so its width
    // is set by the parameter alone and not by the request
    property p_os_down;
        (st_reg.os_cnt != '0) && !(st_reg.cmp_prev && !cmp_n)
            |=> st_reg.os_cnt == $past(st_reg.os_cnt) - 1'h1;
    endproperty
    a_os_down: assert property (p_os_down)
        else $error("one-shot did not count down");

    // the level moves only after the synced button has disagreed
    // with it for the whole debounce count
    property p_deb_hold;
        (st_reg.deb_cnt < DEBOUNCE_CYCLES - 1'h1) |=> $stable(st_reg.req);
    endproperty
    a_deb_hold: assert property (p_deb_hold)
        else $error("request level moved before debounce ended");

    // the pin bit changes only when a fresh bit leaves the buffer,
    // which keeps it steady across every target clock edge
    property p_pin_hold;
        !(bit_out_if.valid && st_reg.consumed) |=> $stable(code_data_out);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pin bit changed without a new bit");
endmodule

// file: verification/scp_target_model.sv
`timescale 1ns/100ps
// stands in for the target chip: latches its code input on each
// rising edge of the gated bit clock, as the real chip does
module scp_target_model
(
    // gated bit clock and serial data from the programmer
    input  wire logic        osc_resistor_pin_in,
    input  wire logic        code_data_in,
    // bench wipes the capture between frames
    input  wire logic        clear_in,
    // captured frame, first bit at the top, and pulse count
    output logic [34:0]      frame_out,
    output logic [7:0]       pulses_out
);
    // --------
    // capture
    // --------
    // a clear is asynchronous so no stale bits leak into a frame
    always @(posedge osc_resistor_pin_in or posedge clear_in)
    begin
        if (clear_in)
        begin
            frame_out  <= 35'h0_0000_0000;  // empty capture
            pulses_out <= 8'h00;
        end
        else
        begin
            frame_out  <= {frame_out[33:0], code_data_in};
            pulses_out <= pulses_out + 8'h01;
        end
    end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    // short counts keep the run brief
    localparam logic [3:0] RST_PAT = 4'ha;  // nonzero shows bit order
    // --------
    // signals
    // --------
    logic        ref_clk;    // system clock
    logic        sys_rst;    // synchronous reset
    logic        btn;        // raw request button
    logic [30:0] sw;         // raw switches, 1 = closed
    logic        bit_clk;    // free-running bit clock
    logic        data;       // serial data to target
    logic        osc;        // gated bit clock to target
    logic        ramp;       // ramp enable one-shot
    logic        busy;       // sequencer status
    logic        tgt_clr;    // wipes the target capture
    logic [34:0] frame;      // bits the target latched
    logic [7:0]  pulses;     // clock pulses the target saw
    logic        ramp_seen;  // sticky: ramp ever rose
    integer      err_total;  // mismatches
    integer      num_checks; // comparisons made

    scp_programmer
    #(
        .RESET_PATTERN   (RST_PAT),
        .DEBOUNCE_CYCLES (21'h0_0008),
        .ONESHOT_CYCLES  (21'h0_0014),
        .POR_CYCLES      (21'h0_0004),
        .FIFO_DEPTH      (16)
    )
    i_dut
    (
        .ref_clk_in                 (ref_clk),
        .sys_rst_in                 (sys_rst),
        .program_request_button_in  (btn),
        .code_switches_closed_in    (sw),
        .bit_clk_in                 (bit_clk),
        .code_data_out              (data),
        .osc_resistor_pin_out       (osc),
        .osc_capacitor_pin_ramp_out (ramp),
        .busy_out                   (busy)
    );

    scp_target_model i_tgt
    (
        .osc_resistor_pin_in (osc),
        .code_data_in        (data),
        .clear_in            (tgt_clr),
        .frame_out           (frame),
        .pulses_out          (pulses)
    );

    // --------
    // clocks
    // --------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // bit clock runs free, offset so its phase is unrelated
    initial
    begin
        bit_clk = 1'b0;
        #3;
        forever #62.5 bit_clk = ~bit_clk;
    end
    // remembers any ramp pulse, even between checks
    always @(posedge ref_clk)
    begin
        if (ramp === 1'b1)
            ramp_seen <= 1'b1;
    end

    // --------
    // helpers
    // --------
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task automatic complete_run();
    begin
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // settled sample point one step after the edge
    task automatic tick(input int n);
    begin
        repeat (n) @(posedge ref_clk);
        #1;
    end
    endtask

    // a hang counts as a mismatch and ends the run
    task automatic hang();
    begin
        err_total = err_total + 1;
        $display("[ERR] %0t wait ran out", $time);
        complete_run();
    end
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
    begin
        n = 0;
        while (busy !== lvl && n < 200)
        begin
            tick(1);
            n = n + 1;
        end
        if (n == 200)
            hang();
    end
    endtask

    // --------
    // scenarios
    // --------
    // nothing stirs after reset
    task automatic t_reset();
    begin
        check({31'h0, busy, ramp, osc, data}, 35'h0);
        tick(50);
        check({34'h0, ramp_seen}, 35'h0);
    end
    endtask

    // a full frame with a given switch setting
    task automatic t_frame(input logic [30:0] sw_val);
        int n;
    begin
        @(posedge ref_clk);
        sw      <= sw_val;
        tgt_clr <= 1'b1;
        @(posedge ref_clk);
        tgt_clr <= 1'b0;
        tick(8);
        @(posedge ref_clk);
        btn <= 1'b1;
        wait_busy(1'b1);
        n = 0;
        while (ramp !== 1'b1 && n < 1000)
        begin
            tick(1);
            n = n + 1;
        end
        if (n == 1000)
            hang();
        check({27'h0, pulses}, 35'd35);
        check(frame, {RST_PAT, ~sw_val});
        n = 0;
        while (ramp === 1'b1 && n < 100)
        begin
            tick(1);
            n = n + 1;
        end
        check(35'(n), 35'd20);
        tick(40);
        check({27'h0, pulses}, 35'd35);
        check({34'h0, osc}, 35'h0);
        @(posedge ref_clk);
        btn <= 1'b0;
        wait_busy(1'b0);
    end
    endtask

    // short bounce is ignored
    task automatic t_bounce();
    begin
        @(posedge ref_clk);
        btn <= 1'b1;
        tick(3);
        @(posedge ref_clk);
        btn <= 1'b0;
        tick(60);
        check({34'h0, busy}, 35'h0);
    end
    endtask

    // early release stops the frame and fires no ramp
    task automatic t_abort();
        int n;
    begin
        @(posedge ref_clk);
        tgt_clr   <= 1'b1;
        ramp_seen <= 1'b0;
        @(posedge ref_clk);
        tgt_clr <= 1'b0;
        btn     <= 1'b1;
        wait_busy(1'b1);
        n = 0;
        while (pulses < 8'd5 && n < 500)
        begin
            tick(1);
            n = n + 1;
        end
        if (n == 500)
            hang();
        @(posedge ref_clk);
        btn <= 1'b0;
        wait_busy(1'b0);
        tick(600);
        check({34'h0, ramp_seen}, 35'h0);
        check({34'h0, pulses < 8'd35}, 35'h1);
    end
    endtask

    // --------
    // main
    // --------
    initial
    begin
        err_total  = 0;
        num_checks = 0;
        sys_rst    = 1'b1;
        btn        = 1'b0;
        sw         = 31'h0000_0000;
        tgt_clr    = 1'b0;
        ramp_seen  = 1'b0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(1);
        t_reset();
        t_frame(31'h5a5a_1234);
        t_bounce();
        t_abort();
        t_frame(31'h7000_00ff);
        t_frame(31'h7fff_ffff);
        complete_run();
    end
endmodule
